// [hdl/dacs_pkg.sv]
// constants and types shared by the diagnostic converter channel sequencer
package dacs_pkg;

	// ====================================================================
	// clocking
	// ====================================================================
	localparam int unsigned DACS_REF_CLK_HZ     = 250_000_000; // ref_clk_i rate
	localparam int unsigned DACS_OSC_HZ         = 1_228_800;   // internal oscillator
	localparam int unsigned DACS_OSC_DIV        = 16;          // converter clock divider
	localparam int unsigned DACS_ADC_CLK_HZ     = DACS_OSC_HZ / DACS_OSC_DIV; // 76.8 kHz
	// period of one converter clock in ref clocks, rounded down
	localparam int unsigned DACS_TICK_CYCLES    = DACS_REF_CLK_HZ / DACS_ADC_CLK_HZ;
	localparam int unsigned DACS_MIN_CONV_TICKS = 20;          // least ticks per conversion

	// ====================================================================
	// input buffer settling
	// ====================================================================
	localparam int unsigned DACS_BUF_WAIT_US     = 210;        // least settling time
	// least time, rounded up to whole cycles
	localparam int unsigned DACS_BUF_WAIT_CYCLES =
		(DACS_BUF_WAIT_US * (DACS_REF_CLK_HZ / 1000) + 999) / 1000;

	// ====================================================================
	// conversion rates, as converter clock ticks per slot
	// ====================================================================
	localparam int unsigned DACS_RATE_FIXED_HZ = 2560;         // internal nodes
	localparam int unsigned DACS_RATE0_HZ      = 640;
	localparam int unsigned DACS_RATE1_HZ      = 1280;
	localparam int unsigned DACS_RATE2_HZ      = 2560;
	localparam int unsigned DACS_RATE3_HZ      = 3840;
	localparam logic [7:0] DACS_TICKS_FIXED = 8'(DACS_ADC_CLK_HZ / DACS_RATE_FIXED_HZ);
	localparam logic [7:0] DACS_TICKS_R0    = 8'(DACS_ADC_CLK_HZ / DACS_RATE0_HZ);
	localparam logic [7:0] DACS_TICKS_R1    = 8'(DACS_ADC_CLK_HZ / DACS_RATE1_HZ);
	localparam logic [7:0] DACS_TICKS_R2    = 8'(DACS_ADC_CLK_HZ / DACS_RATE2_HZ);
	localparam logic [7:0] DACS_TICKS_R3    = 8'(DACS_ADC_CLK_HZ / DACS_RATE3_HZ);

	// ====================================================================
	// slot map
	// ====================================================================
	localparam int unsigned DACS_SLOTS       = 16;
	localparam logic [3:0]  DACS_SLOT_OFFSET = 4'h0;  // reference half
	localparam logic [3:0]  DACS_SLOT_EXT_A  = 4'h1;
	localparam logic [3:0]  DACS_SLOT_EXT_B  = 4'h2;
	localparam logic [3:0]  DACS_SLOT_TEMP   = 4'h3;
	localparam logic [3:0]  DACS_SLOT_DIAG_FIRST = 4'h4; // diag_node_reference
	localparam logic [3:0]  DACS_SLOT_DIAG_LAST  = 4'h8; // diag_node_dac_output
	// slots 9 to 15 sample ground

	// ====================================================================
	// register offsets and reset values
	// ====================================================================
	localparam logic [7:0]  DACS_OFS_EXT_A_RESULT = 8'h24;
	localparam logic [7:0]  DACS_OFS_EXT_B_RESULT = 8'h25;
	localparam logic [7:0]  DACS_OFS_TEMP_RESULT  = 8'h26;
	localparam logic [7:0]  DACS_OFS_OFFSET_VALUE = 8'h28;
	localparam logic [3:0]  DACS_RST_START_INDEX  = 4'h0;
	localparam logic [3:0]  DACS_RST_STOP_INDEX   = 4'h8;
	localparam logic        DACS_RST_ONESHOT      = 1'b0;   // continuous after reset
	localparam logic [1:0]  DACS_RST_RATE         = 2'h0;
	localparam logic        DACS_RST_BUF_PD       = 1'b1;
	localparam logic [15:0] DACS_RST_RESULT       = 16'h0000;
	localparam logic [11:0] DACS_OFFSET_MID       = 12'h7FF; // ideal half-reference code
	localparam logic [11:0] DACS_CODE_MAX         = 12'hFFF;

	// sequencer states
	typedef enum logic [1:0] {
		DACS_IDLE     = 2'b00,
		DACS_WAIT_BUF = 2'b01,
		DACS_CONVERT  = 2'b10
	} dacs_state_e;

endpackage

// [hdl/dacs_tick_gen.sv]
// free-running converter clock tick from the reference clock
`timescale 1ns/1ns
`default_nettype none
module dacs_tick_gen
	import dacs_pkg::*;
#(
	parameter int unsigned DIV = DACS_TICK_CYCLES // ref clocks per tick
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	output logic      tick_o
);

	// ====================================================================
	// divider
	// ====================================================================
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt; // position within one tick period

	// wrap at the last count and flag it
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end else if (cnt == LAST) begin
			cnt    <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + 1'b1;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [hdl/dacs_offset_corr.sv]
// offset correction of a raw code, saturating to the 12-bit range
`timescale 1ns/1ns
`default_nettype none
module dacs_offset_corr
	import dacs_pkg::*;
(
	input  wire logic [11:0] raw_i,        // raw straight binary code
	input  wire logic [15:0] offset_i,     // stored offset, two's complement
	input  wire logic        skip_i,       // report raw code
	output logic      [11:0] corrected_o
);

	// ====================================================================
	// subtract and clamp
	// ====================================================================
	logic signed [16:0] diff; // wide enough for any raw minus offset

	// clamp so a large offset never wraps a code around the scale
	always_comb begin
		diff = signed'({5'h00, raw_i}) - signed'({offset_i[15], offset_i});
		if (skip_i) begin
			corrected_o = raw_i;
		end else if (diff < 0) begin
			corrected_o = 12'h000;
		end else if (diff > signed'({5'h00, DACS_CODE_MAX})) begin
			corrected_o = DACS_CODE_MAX;
		end else begin
			corrected_o = diff[11:0];
		end
	end

endmodule
`default_nettype wire

// [hdl/dacs_sequencer.sv]
// diagnostic converter channel sequencer: slots, modes, trigger, results
//
// Functional notes
// - sixteen slots bounded by start and stop
// - one-shot runs start to stop once
// - continuous loops start to stop while enabled
// - fixed slot map, ground on 9-15
// - internal slots fixed 2560 Hz rate
// - equal indices convert one slot only
// - reset defaults start 0, stop 8
// - second input not analog reads zero
// - start above stop acts as stop
// - continuous clear stops after current slot
// - one-shot trigger self-clears at end
// - at least 20 ticks, oscillator/16
// - low supply blocks span bit set
// - span bit: 0 double, 1 single reference
// - external rate 640/1280/2560/3840 Hz
// - idle shows busy low, trigger zero
// - results hold newest, reads never stall
// - offset stored as 7FFh minus conversion
// - offset subtracted unless skip enabled
// - external results straight binary 12-bit
// - results to 24h, 25h, 26h
// - mode bit one means one-shot
`timescale 1ns/1ns
`default_nettype none
module dacs_sequencer
	import dacs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES     = DACS_TICK_CYCLES,     // ref clocks per tick
	parameter int unsigned BUF_WAIT_CYCLES = DACS_BUF_WAIT_CYCLES  // buffer settling
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// configuration write, one cycle strobe with all fields
	input  wire logic        cfg_wr_i,
	input  wire logic [3:0]  cfg_start_index_i,
	input  wire logic [3:0]  cfg_stop_index_i,
	input  wire logic        cfg_oneshot_i,
	input  wire logic [1:0]  cfg_input_rate_select_i,
	input  wire logic        cfg_input_span_select_i,
	input  wire logic        cfg_input_buffer_powerdown_i,
	input  wire logic        cfg_offset_skip_enable_i,
	input  wire logic        cfg_ext_input_b_analog_i,
	// trigger bit write
	input  wire logic        trig_wr_i,
	input  wire logic        trig_data_i,
	// supply level comparator, asynchronous
	input  wire logic        analog_supply_high_i,
	// converter macro
	input  wire logic [11:0] conv_data_i,
	output logic             conv_start_o,
	output logic      [3:0]  conv_slot_o,
	output logic             conv_span_single_o,
	output logic             input_buffer_powerdown_o,
	// readback
	output logic             trigger_o,
	output logic             busy_o,
	output logic             span_select_o,
	output logic      [15:0] ext_input_a_result_o,
	output logic      [15:0] ext_input_b_result_o,
	output logic      [15:0] die_temperature_result_o,
	output logic      [15:0] converter_offset_value_o,
	output logic             result_valid_o,
	output logic      [3:0]  result_slot_o,
	output logic      [11:0] result_data_o
);

	// ====================================================================
	// declarations
	// ====================================================================
	localparam int unsigned BW = (BUF_WAIT_CYCLES > 1) ? $clog2(BUF_WAIT_CYCLES + 1) : 1;
	localparam logic [BW-1:0] BUF_LAST = BW'(BUF_WAIT_CYCLES);

	logic [3:0]    start_index;    // first slot as written
	logic [3:0]    stop_index;     // last slot as written
	logic          oneshot_mode;   // 1 one-shot, 0 continuous
	logic [1:0]    rate_sel;       // external input rate
	logic          span_sel;       // external input span
	logic          buf_pd;         // input buffer power-down request
	logic          offset_skip;    // report raw codes
	logic          ext_b_analog;   // second input used as analog
	logic          trigger;        // trigger bit
	logic          supply_meta;    // first stage, read only by the second
	logic          supply_high;    // synchronised supply level
	logic [BW-1:0] buf_cnt;        // settling timer
	logic          buf_ready;      // settling time elapsed
	dacs_state_e   state;          // sequencer state
	logic [3:0]    slot;           // slot in conversion
	logic [7:0]    tick_cnt;       // ticks spent in the slot
	logic [7:0]    slot_len;       // ticks the slot needs
	logic          tick;           // converter clock tick
	logic          slot_end;       // last tick of the slot
	logic [3:0]    first_slot;     // effective start
	logic [3:0]    next_slot;      // slot that the next start enters
	logic          seq_last;       // slot is the stop slot
	logic          enter;          // a slot begins this cycle
	logic          oneshot_done;   // one-shot sequence finished
	logic [11:0]   raw_code;       // code after input gating
	logic [11:0]   corr_code;      // code after offset correction
	logic [12:0]   ofs_diff;       // mid code minus offset slot code

	// ====================================================================
	// functions
	// ====================================================================
	// ticks per slot: internal nodes fixed, external inputs by rate
	function automatic logic [7:0] slot_ticks(input logic [3:0] s, input logic [1:0] r);
		logic [7:0] t;
		t = DACS_TICKS_FIXED;
		if (s == DACS_SLOT_EXT_A || s == DACS_SLOT_EXT_B) begin
			case (r)
				2'h0:    t = DACS_TICKS_R0;
				2'h1:    t = DACS_TICKS_R1;
				2'h2:    t = DACS_TICKS_R2;
				default: t = DACS_TICKS_R3;
			endcase
		end
		return t;
	endfunction

	// effective span: 1 means one reference
	function automatic logic span_single(input logic [3:0] s, input logic sel,
			input logic hi);
		logic v;
		v = 1'b1;                                  // one reference for internal nodes
		if (s == DACS_SLOT_EXT_A || s == DACS_SLOT_EXT_B) begin
			v = hi ? sel : 1'b1;
		end else if (s == DACS_SLOT_DIAG_LAST) begin
			v = !hi;                               // output monitor doubles at high supply
		end
		return v;
	endfunction

	// ====================================================================
	// sub-blocks
	// ====================================================================
	dacs_tick_gen #(
		.DIV (TICK_CYCLES)
	) u_tick (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.tick_o    (tick)
	);

	dacs_offset_corr u_corr (
		.raw_i       (raw_code),
		.offset_i    (converter_offset_value_o),
		.skip_i      (offset_skip),
		.corrected_o (corr_code)
	);

	// ====================================================================
	// supply level synchroniser
	// ====================================================================
	// two stages, the pin is asynchronous to ref_clk_i
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			supply_meta <= 1'b0;
			supply_high <= 1'b0;
		end else begin
			supply_meta <= analog_supply_high_i;
			supply_high <= supply_meta;
		end
	end

	// ====================================================================
	// configuration register
	// ====================================================================
	// written only when idle per host practice; no hardware lock
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			start_index  <= DACS_RST_START_INDEX;
			stop_index   <= DACS_RST_STOP_INDEX;
			oneshot_mode <= DACS_RST_ONESHOT;
			rate_sel     <= DACS_RST_RATE;
			span_sel     <= 1'b0;
			buf_pd       <= DACS_RST_BUF_PD;
			offset_skip  <= 1'b0;
			ext_b_analog <= 1'b0;
		end else if (cfg_wr_i) begin
			start_index  <= cfg_start_index_i;
			stop_index   <= cfg_stop_index_i;
			oneshot_mode <= cfg_oneshot_i;
			rate_sel     <= cfg_input_rate_select_i;
			span_sel     <= cfg_input_span_select_i & supply_high;
			buf_pd       <= cfg_input_buffer_powerdown_i;
			offset_skip  <= cfg_offset_skip_enable_i;
			ext_b_analog <= cfg_ext_input_b_analog_i;
		end
	end

	// ====================================================================
	// buffer settling timer
	// ====================================================================
	// restarts whenever the buffer is powered down
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || buf_pd) begin
			buf_cnt <= '0;
		end else if (buf_cnt != BUF_LAST) begin
			buf_cnt <= buf_cnt + 1'b1;
		end
	end
	assign buf_ready = (buf_cnt == BUF_LAST);

	// ====================================================================
	// sequencing terms
	// ====================================================================
	assign first_slot   = (start_index > stop_index) ? stop_index : start_index;
	assign seq_last     = (slot == stop_index);
	assign next_slot    = ((state == DACS_WAIT_BUF) || seq_last) ? first_slot : slot + 4'h1;
	assign slot_len     = slot_ticks(slot, rate_sel);
	assign slot_end     = (state == DACS_CONVERT) && tick && (tick_cnt == slot_len - 8'h01);
	assign oneshot_done = slot_end && oneshot_mode && seq_last;
	assign enter        = ((state == DACS_WAIT_BUF) && trigger && !buf_pd && buf_ready)
		|| (slot_end && !(oneshot_mode ? seq_last : (!trigger || buf_pd)));

	// ====================================================================
	// trigger bit
	// ====================================================================
	// a host write in the finishing cycle wins over the self-clear
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			trigger <= 1'b0;
		end else if (trig_wr_i) begin
			trigger <= trig_data_i;
		end else if (oneshot_done) begin
			trigger <= 1'b0;
		end
	end

	// ====================================================================
	// sequencer state machine
	// ====================================================================
	// a slot always runs to its end, so stopping never cuts a conversion
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state <= DACS_IDLE;
			slot  <= 4'h0;
		end else begin
			case (state)
				DACS_IDLE: begin
					if (trigger) begin
						state <= DACS_WAIT_BUF;
					end
				end
				DACS_WAIT_BUF: begin
					if (!trigger || buf_pd) begin
						state <= DACS_IDLE;
					end else if (buf_ready) begin
						state <= DACS_CONVERT;
						slot  <= first_slot;
					end
				end
				DACS_CONVERT: begin
					if (slot_end) begin
						if (oneshot_mode && seq_last) begin
							state <= DACS_IDLE;
						end else if (!oneshot_mode && (!trigger || buf_pd)) begin
							state <= DACS_IDLE;
						end else if (seq_last || slot > stop_index) begin
							slot  <= first_slot;
						end else begin
							slot  <= slot + 4'h1;
						end
					end
				end
				default: begin
					state <= DACS_IDLE;
				end
			endcase
		end
	end

	// ticks within the slot, restarted at each slot start
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || enter) begin
			tick_cnt <= 8'h00;
		end else if ((state == DACS_CONVERT) && tick) begin
			tick_cnt <= tick_cnt + 8'h01;
		end
	end

	// ====================================================================
	// converter macro controls
	// ====================================================================
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			conv_start_o             <= 1'b0;
			conv_slot_o              <= 4'h0;
			conv_span_single_o       <= 1'b1;
			input_buffer_powerdown_o <= DACS_RST_BUF_PD;
		end else begin
			conv_start_o             <= enter;
			conv_slot_o              <= enter ? next_slot : conv_slot_o;
			// span follows the slot being entered, so it is right at the start pulse
			conv_span_single_o       <= span_single(enter ? next_slot : conv_slot_o, span_sel,
				supply_high);
			// power-down waits until the sequence is over: the current slot when continuous, the stop slot when one-shot
			input_buffer_powerdown_o <= buf_pd && (state != DACS_CONVERT);
		end
	end

	// ====================================================================
	// result capture
	// ====================================================================
	// gated second input still spends its full slot time
	assign raw_code = ((slot == DACS_SLOT_EXT_B) && !ext_b_analog) ? 12'h000 : conv_data_i;
	assign ofs_diff = {1'b0, DACS_OFFSET_MID} - {1'b0, conv_data_i};

	// registers update only at slot end; reads are plain wires
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ext_input_a_result_o     <= DACS_RST_RESULT;
			ext_input_b_result_o     <= DACS_RST_RESULT;
			die_temperature_result_o <= DACS_RST_RESULT;
			converter_offset_value_o <= DACS_RST_RESULT;
		end else if (slot_end) begin
			case (slot)
				DACS_SLOT_OFFSET: converter_offset_value_o <= {{3{ofs_diff[12]}}, ofs_diff};
				DACS_SLOT_EXT_A:  ext_input_a_result_o     <= {4'h0, corr_code};
				DACS_SLOT_EXT_B:  ext_input_b_result_o     <= {4'h0,
					(ext_b_analog ? corr_code : 12'h000)};
				DACS_SLOT_TEMP:   die_temperature_result_o <= {4'h0, corr_code};
				default: begin
					// diagnostic and ground slots go to the result stream only
				end
			endcase
		end
	end

	// result stream for every slot, one-cycle pulse
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			result_valid_o <= 1'b0;
			result_slot_o  <= 4'h0;
			result_data_o  <= 12'h000;
		end else begin
			result_valid_o <= slot_end;
			if (slot_end) begin
				result_slot_o <= slot;
				result_data_o <= (slot == DACS_SLOT_OFFSET) ? conv_data_i : corr_code;
			end
		end
	end

	// ====================================================================
	// status
	// ====================================================================
	assign trigger_o     = trigger;
	assign busy_o        = (state != DACS_IDLE);
	assign span_select_o = span_sel;

endmodule
`default_nettype wire

// [tb/dacs_sequencer_sva.sv]
// assertion checker watching the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module dacs_sequencer_sva
	import dacs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES     = DACS_TICK_CYCLES,
	parameter int unsigned BUF_WAIT_CYCLES = DACS_BUF_WAIT_CYCLES
) (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        trig_wr_i,
	input wire logic        analog_supply_high_i,
	input wire logic        conv_start_o,
	input wire logic [3:0]  conv_slot_o,
	input wire logic        conv_span_single_o,
	input wire logic        trigger_o,
	input wire logic        busy_o,
	input wire logic        span_select_o,
	input wire logic [15:0] ext_input_a_result_o,
	input wire logic [15:0] ext_input_b_result_o,
	input wire logic [15:0] die_temperature_result_o,
	input wire logic [15:0] converter_offset_value_o,
	input wire logic        result_valid_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// helper: clocks since the last slot start, saturating
	// ==========================================================
	logic [15:0] gap; // starts high so the first slot is not judged
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) gap <= 16'hFFFF;
		else if (conv_start_o) gap <= 16'h0000;
		else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
	end
	// ==========================================================
	// properties
	// ==========================================================
	property p_busy_on_start; conv_start_o |-> busy_o; endproperty
	a_busy_on_start: assert property (p_busy_on_start) else $error("slot start while idle");
	property p_slot_gap; conv_start_o |-> gap >= 16'(19 * TICK_CYCLES - 1); endproperty
	a_slot_gap: assert property (p_slot_gap) else $error("slot shorter than minimum");
	property p_start_needs_trig;
		conv_start_o |-> $past(trigger_o) || $past(trigger_o, 2) || $past(trigger_o, 3);
	endproperty
	a_start_needs_trig: assert property (p_start_needs_trig) else $error("slot without trigger");
	property p_span_ext; conv_start_o && (conv_slot_o == 4'h1 || conv_slot_o == 4'h2)
		|-> conv_span_single_o == (span_select_o || !analog_supply_high_i); endproperty
	a_span_ext: assert property (p_span_ext) else $error("external span wrong");
	property p_span_int; conv_start_o && conv_slot_o != 4'h1 && conv_slot_o != 4'h2
		&& conv_slot_o != 4'h8 |-> conv_span_single_o; endproperty
	a_span_int: assert property (p_span_int) else $error("internal span wrong");
	property p_span_vout; conv_start_o && conv_slot_o == 4'h8
		|-> conv_span_single_o == !analog_supply_high_i; endproperty
	a_span_vout: assert property (p_span_vout) else $error("output monitor span wrong");
	property p_span_block; $rose(span_select_o) |-> $past(analog_supply_high_i, 3); endproperty
	a_span_block: assert property (p_span_block) else $error("span set at low supply");
	property p_self_clear; $fell(trigger_o) && !$past(trig_wr_i) |-> !busy_o; endproperty
	a_self_clear: assert property (p_self_clear) else $error("busy after self clear");
	property p_hold; $changed({ext_input_a_result_o, ext_input_b_result_o,
		die_temperature_result_o, converter_offset_value_o}) |-> ##[0:1] result_valid_o; endproperty
	a_hold: assert property (p_hold) else $error("result changed without completion");
	property p_idle_quiet; !busy_o |-> !conv_start_o; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("start while idle");
endmodule
`default_nettype wire

// [tb/dacs_conv_model.sv]
// converter macro model: fixed code per slot, scrambled when idle
`timescale 1ns/1ns
`default_nettype none
module dacs_conv_model (
	input  wire logic        ref_clk_i,
	input  wire logic        conv_start_i,
	input  wire logic [3:0]  conv_slot_i,
	input  wire logic        busy_i,
	output logic      [11:0] conv_data_o
);
	initial conv_data_o = 12'h5A5;
	// code per slot; offset slot reads 7F0 so the offset is 00F
	always @(posedge ref_clk_i) begin
		if (conv_start_i) conv_data_o <= (conv_slot_i == 4'h0) ? 12'h7F0 : {conv_slot_i, 8'h40};
		else if (!busy_i) conv_data_o <= ~conv_data_o; // no stale code when idle
	end
endmodule
`default_nettype wire

// [tb/dacs_sequencer_test.sv]
// self-checking bench for the channel sequencer
`timescale 1ns/1ns
`default_nettype none
module dacs_sequencer_test;
	import dacs_pkg::*;
	localparam int unsigned TK = 4;
	logic clk, rst_n, cw, os, span, bpd, skip, banl, tw, td, sup, cs, csp, ibpd, trg, busy, spo, rv;
	logic [3:0] st, sp, cslot, rslot;
	logic [1:0] rate;
	logic [11:0] cdata, rdata;
	logic [15:0] ra, rb, rt, ro;
	int failures, num_checks, cyc, t0, dur, k;
	logic [3:0] seen[$];
	logic [7:0] lens[4];
	dacs_sequencer #(.TICK_CYCLES(TK), .BUF_WAIT_CYCLES(10)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
		.cfg_wr_i(cw), .cfg_start_index_i(st), .cfg_stop_index_i(sp), .cfg_oneshot_i(os),
		.cfg_input_rate_select_i(rate), .cfg_input_span_select_i(span),
		.cfg_input_buffer_powerdown_i(bpd), .cfg_offset_skip_enable_i(skip),
		.cfg_ext_input_b_analog_i(banl), .trig_wr_i(tw), .trig_data_i(td),
		.analog_supply_high_i(sup), .conv_data_i(cdata), .conv_start_o(cs), .conv_slot_o(cslot),
		.conv_span_single_o(csp), .input_buffer_powerdown_o(ibpd), .trigger_o(trg), .busy_o(busy),
		.span_select_o(spo), .ext_input_a_result_o(ra), .ext_input_b_result_o(rb),
		.die_temperature_result_o(rt), .converter_offset_value_o(ro), .result_valid_o(rv),
		.result_slot_o(rslot), .result_data_o(rdata));
	dacs_conv_model i_conv (.ref_clk_i(clk), .conv_start_i(cs), .conv_slot_i(cslot), .busy_i(busy),
		.conv_data_o(cdata));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// completed slots and the time the last one took
	always @(posedge clk) begin
		cyc++;
		if (cs === 1'b1) t0 = cyc;
		if (rv === 1'b1) begin
			seen.push_back(rslot);
			dur = cyc - t0;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cfg(input logic [3:0] a, b, input logic o, input logic [1:0] r, input logic s, k2, n);
		@(posedge clk);
		{cw, st, sp, os, rate, span, bpd, skip, banl} <= {1'b1, a, b, o, r, s, 1'b0, k2, n};
		@(posedge clk);
		cw <= 1'b0;
	endtask
	task automatic trig(input logic v);
		@(posedge clk);
		{tw, td} <= {1'b1, v};
		@(posedge clk);
		tw <= 1'b0;
	endtask
	// one-shot run: trigger, then wait for idle
	task automatic run;
		int n;
		seen.delete();
		trig(1'b1);
		for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
		@(negedge clk); // let the last result pulse be recorded
		chk("trigger", 16'h0, trg);
	endtask
	task automatic results;
		if (failures == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results;
	end
	initial begin
		{rst_n, cw, os, span, skip, banl, tw, td, st, sp, rate} = '0;
		{bpd, sup} = 2'b11;
		lens = '{DACS_TICKS_R0, DACS_TICKS_R1, DACS_TICKS_R2, DACS_TICKS_R3};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("reset", 16'h2000, {busy, trg, ibpd, ra[12:0] | ro[12:0]});
		cfg(4'h0, 4'h8, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
		run;
		chk("stream", 16'h0831, {3'h0, ibpd, rdata});
		chk("count", 16'd9, 16'(seen.size()));
		for (int i = 0; i < 9; i++) chk("slot", 16'(i), {12'h0, seen[i]});
		chk("offset", 16'h000F, ro);
		chk("input a", 16'h0131, ra);
		chk("input b", 16'h0000, rb);
		chk("temp", 16'h0331, rt);
		cfg(4'h5, 4'h2, 1'b1, 2'h3, 1'b0, 1'b1, 1'b1);
		run;
		chk("single", 16'h0002, {12'h0, seen[0]});
		chk("raw b", 16'h0240, rb);
		for (int i = 0; i < 4; i++) begin
			cfg(4'h1, 4'h1, 1'b1, 2'(i), i[0], 1'b0, 1'b0);
			run;
			chk("one slot", 16'h0001, 16'(seen.size()));
			chk("rate", 16'h1, 16'(dur >= (lens[i] - 1) * TK && dur <= lens[i] * TK + 2));
		end
		sup <= 1'b0;
		repeat (3) @(posedge clk); // let the supply synchroniser settle
		cfg(4'h1, 4'h1, 1'b1, 2'h3, 1'b1, 1'b0, 1'b0);
		@(negedge clk);
		chk("span", 16'h0000, {15'h0, spo});
		run;
		sup <= 1'b1;
		seen.delete();
		cfg(4'h3, 4'h4, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
		trig(1'b1);
		for (int n = 0; n < 3000 && seen.size() < 3; n++) @(negedge clk);
		k = seen.size();
		trig(1'b0);
		for (int n = 0; n < 500 && busy !== 1'b0; n++) @(negedge clk);
		chk("loop", 16'h0343, {4'h0, seen[0], seen[1], seen[2]});
		chk("stop", 16'h1, 16'(busy === 1'b0 && seen.size() <= k + 1));
		results;
	end
endmodule
bind dacs_sequencer dacs_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES),
	.BUF_WAIT_CYCLES(BUF_WAIT_CYCLES)) i_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.trig_wr_i(trig_wr_i), .analog_supply_high_i(analog_supply_high_i),
	.conv_start_o(conv_start_o), .conv_slot_o(conv_slot_o),
	.conv_span_single_o(conv_span_single_o), .trigger_o(trigger_o), .busy_o(busy_o),
	.span_select_o(span_select_o), .ext_input_a_result_o(ext_input_a_result_o),
	.ext_input_b_result_o(ext_input_b_result_o),
	.die_temperature_result_o(die_temperature_result_o),
	.converter_offset_value_o(converter_offset_value_o), .result_valid_o(result_valid_o));
`default_nettype wire
